// ### verilog/sdbc_pkg.sv
// Shared constants and types for the two-channel block count and argument bank.
package sdbc_pkg;

    // Number of channels and field widths.
    localparam int NUM_CH = 2;
    localparam int CNT_W = 16;
    localparam int ARG_W = 32;

    // Register indices; the byte address is the index shifted left by two.
    localparam logic [31:0] IDX_REMAINING_BLOCKS_CH0 = 32'h4AC00006;
    localparam logic [31:0] IDX_COMMAND_ARGUMENT_CH0 = 32'h4AC00008;
    localparam logic [31:0] IDX_REMAINING_BLOCKS_CH1 = 32'h4A800006;
    localparam logic [31:0] IDX_COMMAND_ARGUMENT_CH1 = 32'h4A800008;
    localparam int IDX_SHIFT = 2;

    // Values after reset, and the read data of unmapped addresses.
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [31:0] ARG_RESET = 32'h00000000;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;

    // Special counter values.
    localparam logic [15:0] CNT_STOP = 16'h0000;
    localparam logic [15:0] CNT_LAST = 16'h0001;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // Position of the argument inside the outgoing command frame.
    localparam int FRAME_ARG_MSB = 39;
    localparam int FRAME_ARG_LSB = 8;

    // Per-channel transfer state, Gray along idle to run.
    typedef enum logic [0:0] {
        SDBC_IDLE = 1'b0,
        SDBC_RUN = 1'b1
    } sdbc_state_e;

endpackage : sdbc_pkg

// ### verilog/sdbc_chan.sv
// One channel: block counter, argument register and counted-transfer tracking.
module sdbc_chan (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Register writes from the bus slave.
    input wire logic wr_cnt,
    input wire logic wr_arg,
    input wire logic [31:0] wdata,
    // Transfer controls from the data engine.
    input wire logic xfer_active,
    input wire logic xfer_start,
    input wire logic block_done,
    input wire logic count_gate_bit,
    input wire logic multi_block_select,
    input wire logic auto_stop_command_enable,
    // Register contents and events.
    output logic [15:0] remaining_blocks,
    output logic [31:0] command_argument,
    output logic transfer_end,
    output logic auto_stop_issue,
    output logic empty_start
);

    sdbc_pkg::sdbc_state_e state;
    sdbc_pkg::sdbc_state_e next_state;
    logic [15:0] next_remaining_blocks;
    logic [31:0] next_command_argument;
    logic next_transfer_end;
    logic next_auto_stop_issue;
    logic next_empty_start;
    logic counted;
    logic wr_cnt_ok;
    logic last_block;

    assign counted = count_gate_bit && multi_block_select;
    // Writes arriving while the engine is busy are dropped so a running count is never corrupted.
    assign wr_cnt_ok = wr_cnt && !xfer_active;
    assign last_block = (state == sdbc_pkg::SDBC_RUN) && xfer_active && block_done && counted
        && (remaining_blocks == sdbc_pkg::CNT_LAST);

    always_comb begin
        next_state = state;
        next_remaining_blocks = remaining_blocks;
        next_command_argument = command_argument;
        next_transfer_end = 1'b0;
        next_auto_stop_issue = 1'b0;
        next_empty_start = 1'b0;
        if (wr_arg) begin
            next_command_argument = wdata;
        end
        if (wr_cnt_ok) begin
            next_remaining_blocks = wdata[15:0];
        end
        case (state)
            sdbc_pkg::SDBC_IDLE: begin
                if (xfer_start && counted) begin
                    if (remaining_blocks == sdbc_pkg::CNT_STOP) begin
                        next_empty_start = 1'b1;
                    end else begin
                        next_state = sdbc_pkg::SDBC_RUN;
                    end
                end
            end
            sdbc_pkg::SDBC_RUN: begin
                if (!xfer_active) begin
                    // Suspend or stop: the untransferred count stays for context save.
                    next_state = sdbc_pkg::SDBC_IDLE;
                end else if (block_done && counted
                        && remaining_blocks != sdbc_pkg::CNT_STOP) begin
                    next_remaining_blocks = remaining_blocks - sdbc_pkg::CNT_ONE;
                    if (last_block) begin
                        next_transfer_end = 1'b1;
                        next_auto_stop_issue = auto_stop_command_enable;
                        next_state = sdbc_pkg::SDBC_IDLE;
                    end
                end
                // With the gate low the count is left untouched.
            end
            default: begin
                next_state = sdbc_pkg::SDBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= sdbc_pkg::SDBC_IDLE;
            remaining_blocks <= sdbc_pkg::CNT_RESET;
            command_argument <= sdbc_pkg::ARG_RESET;
            transfer_end <= 1'b0;
            auto_stop_issue <= 1'b0;
            empty_start <= 1'b0;
        end else begin
            state <= next_state;
            remaining_blocks <= next_remaining_blocks;
            command_argument <= next_command_argument;
            transfer_end <= next_transfer_end;
            auto_stop_issue <= next_auto_stop_issue;
            empty_start <= next_empty_start;
        end
    end

    sequence s_counted_block;
        (state == sdbc_pkg::SDBC_RUN) && xfer_active && block_done && counted
            && (remaining_blocks != sdbc_pkg::CNT_STOP);
    endsequence

    sequence s_final_block;
        s_counted_block ##0 (remaining_blocks == sdbc_pkg::CNT_LAST);
    endsequence

    a_busy_write_dropped: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_cnt && xfer_active && !block_done) |=> $stable(remaining_blocks))
        else $error("Counter changed by a write during a transfer.");

    a_count_step_down: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_counted_block |=> (remaining_blocks == $past(remaining_blocks) - 16'h0001))
        else $error("Counter did not step down by one on a finished block.");

    a_end_at_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_final_block |=> transfer_end && (remaining_blocks == sdbc_pkg::CNT_STOP)
            && (state == sdbc_pkg::SDBC_IDLE))
        else $error("Transfer did not end when the counter reached zero.");

    a_zero_no_blocks: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((state == sdbc_pkg::SDBC_IDLE) && xfer_start && counted
            && remaining_blocks == sdbc_pkg::CNT_STOP)
        |=> empty_start && (state == sdbc_pkg::SDBC_IDLE) ##1 !transfer_end)
        else $error("A zero count started a counted transfer.");

    a_gate_low_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!count_gate_bit && !wr_cnt_ok) |=> $stable(remaining_blocks))
        else $error("Counter moved while the count gate was low.");

    a_uncounted_no_end: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !multi_block_select |=> !transfer_end && !auto_stop_issue)
        else $error("A single-block transfer was ended by the counter.");

    a_auto_stop_follow: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_final_block ##0 auto_stop_command_enable) |=> auto_stop_issue && transfer_end)
        else $error("Stop command was not issued after the last block.");

    a_suspend_keeps: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((state == sdbc_pkg::SDBC_RUN) && !xfer_active && !wr_cnt)
        |=> (state == sdbc_pkg::SDBC_IDLE) && $stable(remaining_blocks))
        else $error("Remaining count lost on suspend.");

endmodule : sdbc_chan

// ### verilog/sdbc_bank.sv
// AHB-Lite register bank holding both channels' block counters and arguments.

// Function
// - The counter takes part in ending a transfer only when count gating is on and the transfer is multi-block.
// - The counter drops by one per finished block and the transfer ends when it reaches zero.
// - A counter holding zero at the start of a counted transfer moves no blocks.
// - Writes to the counter are discarded while a data transaction runs.
// - After a suspend the counter keeps the number of blocks still to move.
// - Each channel holds a 32-bit argument sent as frame bits 39 to 8.
// - Two independent channels each have a counter and an argument, both reset to zero.
// - The count gate is transfer-mode bit 1; when low the counter is disabled.
// - With auto stop enabled the stop command is issued after the last counted block.
module sdbc_bank (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Per-channel transfer controls, index is the channel.
    input wire logic [1:0] xfer_active,
    input wire logic [1:0] xfer_start,
    input wire logic [1:0] block_done,
    input wire logic [1:0] count_gate_bit,
    input wire logic [1:0] multi_block_select,
    input wire logic [1:0] auto_stop_command_enable,
    // Per-channel results.
    output logic [1:0][39:8] frame_argument,
    output logic [1:0] transfer_end,
    output logic [1:0] auto_stop_issue,
    output logic [1:0] empty_start
);

    logic dp_valid;
    logic dp_write;
    logic [29:0] dp_index;
    logic next_dp_valid;
    logic next_dp_write;
    logic [29:0] next_dp_index;
    logic addr_take;
    logic [1:0] hit_cnt;
    logic [1:0] hit_arg;
    logic [1:0] wr_cnt;
    logic [1:0] wr_arg;
    logic [1:0][15:0] remaining_blocks;
    logic [1:0][31:0] command_argument;

    // The printed indices carry one bit above what a 32-bit byte address can hold,
    // so only the low 30 index bits are decoded and the map aliases once.
    function automatic logic [29:0] cnt_index(input int ch);
        logic [31:0] idx;
        idx = (ch == 0) ? sdbc_pkg::IDX_REMAINING_BLOCKS_CH0
            : sdbc_pkg::IDX_REMAINING_BLOCKS_CH1;
        return idx[29:0];
    endfunction : cnt_index

    function automatic logic [29:0] arg_index(input int ch);
        logic [31:0] idx;
        idx = (ch == 0) ? sdbc_pkg::IDX_COMMAND_ARGUMENT_CH0
            : sdbc_pkg::IDX_COMMAND_ARGUMENT_CH1;
        return idx[29:0];
    endfunction : arg_index

    // Zero wait states and an OKAY answer always; unmapped reads return zero.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_take = hsel && hready && htrans[1];

    always_comb begin
        next_dp_valid = dp_valid;
        next_dp_write = dp_write;
        next_dp_index = dp_index;
        if (hready) begin
            next_dp_valid = addr_take;
            next_dp_write = hwrite;
            next_dp_index = haddr[31:sdbc_pkg::IDX_SHIFT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_index <= 30'h00000000;
        end else begin
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_index <= next_dp_index;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < sdbc_pkg::NUM_CH; ch++) begin : g_ch
            assign hit_cnt[ch] = dp_valid && (dp_index == cnt_index(ch));
            assign hit_arg[ch] = dp_valid && (dp_index == arg_index(ch));
            assign wr_cnt[ch] = hit_cnt[ch] && dp_write;
            assign wr_arg[ch] = hit_arg[ch] && dp_write;
            assign frame_argument[ch] = command_argument[ch];

            sdbc_chan u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_cnt(wr_cnt[ch]),
                .wr_arg(wr_arg[ch]),
                .wdata(hwdata),
                .xfer_active(xfer_active[ch]),
                .xfer_start(xfer_start[ch]),
                .block_done(block_done[ch]),
                .count_gate_bit(count_gate_bit[ch]),
                .multi_block_select(multi_block_select[ch]),
                .auto_stop_command_enable(auto_stop_command_enable[ch]),
                .remaining_blocks(remaining_blocks[ch]),
                .command_argument(command_argument[ch]),
                .transfer_end(transfer_end[ch]),
                .auto_stop_issue(auto_stop_issue[ch]),
                .empty_start(empty_start[ch])
            );

            a_arg_written: assert property (
                @(posedge hclk) disable iff (!hresetn)
                wr_arg[ch] |=> frame_argument[ch] == $past(hwdata))
                else $error("Argument register did not take the written word.");
        end
    endgenerate

    // Read data is a mux of flops; a counter read mid-transfer shows the live count.
    always_comb begin
        hrdata = sdbc_pkg::RDATA_UNMAPPED;
        if (dp_valid && !dp_write) begin
            if (hit_cnt[0]) begin
                hrdata = {16'h0000, remaining_blocks[0]};
            end else if (hit_cnt[1]) begin
                hrdata = {16'h0000, remaining_blocks[1]};
            end else if (hit_arg[0]) begin
                hrdata = command_argument[0];
            end else if (hit_arg[1]) begin
                hrdata = command_argument[1];
            end else begin
                hrdata = sdbc_pkg::RDATA_UNMAPPED;
            end
        end
    end

    a_count_readback: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_valid && !dp_write && (dp_index == cnt_index(1)))
        |-> hrdata == {16'h0000, remaining_blocks[1]})
        else $error("Channel one counter read returned wrong data.");

    a_chan_isolated: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_cnt[0] && !block_done[1] && !wr_cnt[1]) |=> $stable(remaining_blocks[1]))
        else $error("Write to channel zero disturbed channel one.");

endmodule : sdbc_bank

// ### test/sdbc_engine.sv
// Data engine model that starts, paces and suspends transfers on each channel.
module sdbc_engine (
    // Clock.
    input wire logic hclk,
    // Transfer controls towards the bank.
    output logic [1:0] xfer_active,
    output logic [1:0] xfer_start,
    output logic [1:0] block_done
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        xfer_active = 2'h0;
        xfer_start = 2'h0;
        block_done = 2'h0;
    end

    // Fewer blocks than were loaded models a suspend, since activity then drops early.
    task automatic run(input int ch, input int nblk, input int gap);
        @(posedge hclk);
        xfer_active[ch] <= 1'b1;
        xfer_start[ch] <= 1'b1;
        @(posedge hclk);
        xfer_start[ch] <= 1'b0;
        for (int i = 0; i < nblk; i++) begin
            block_done[ch] <= 1'b1;
            @(posedge hclk);
            if (gap > 0) begin
                block_done[ch] <= 1'b0;
                repeat (gap) @(posedge hclk);
            end
        end
        block_done[ch] <= 1'b0;
        repeat (2) @(posedge hclk);
        xfer_active[ch] <= 1'b0;
        @(posedge hclk);
    endtask : run
endmodule : sdbc_engine

// ### test/sdbc_bank_tb_top.sv
// Self-checking testbench for the two-channel block count and argument bank.
module sdbc_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, seed, rd, v;
    logic [1:0] htrans, xfer_active, xfer_start, block_done, count_gate_bit;
    logic [1:0] multi_block_select, auto_stop_command_enable, transfer_end;
    logic [1:0] auto_stop_issue, empty_start;
    logic [2:0] hsize;
    logic [1:0][39:8] frame_argument;
    int error_cnt, tests_run, te_n[2], as_n[2], es_n[2], c;

    sdbc_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .xfer_active(xfer_active), .xfer_start(xfer_start), .block_done(block_done),
        .count_gate_bit(count_gate_bit), .multi_block_select(multi_block_select),
        .auto_stop_command_enable(auto_stop_command_enable),
        .frame_argument(frame_argument), .transfer_end(transfer_end),
        .auto_stop_issue(auto_stop_issue), .empty_start(empty_start));
    sdbc_engine eng (.hclk(hclk), .xfer_active(xfer_active), .xfer_start(xfer_start),
        .block_done(block_done));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // Pulses are counted at the falling edge, clear of the edge that launches them.
    always @(negedge hclk) begin
        for (int k = 0; k < 2; k++) begin
            te_n[k] += int'(transfer_end[k] === 1'b1);
            as_n[k] += int'(auto_stop_issue[k] === 1'b1);
            es_n[k] += int'(empty_start[k] === 1'b1);
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] adr(input int ch, input bit arg);
        logic [31:0] i;
        if (arg) begin
            i = ch ? sdbc_pkg::IDX_COMMAND_ARGUMENT_CH1 : sdbc_pkg::IDX_COMMAND_ARGUMENT_CH0;
        end else begin
            i = ch ? sdbc_pkg::IDX_REMAINING_BLOCKS_CH1 : sdbc_pkg::IDX_REMAINING_BLOCKS_CH0;
        end
        return i << sdbc_pkg::IDX_SHIFT;
    endfunction : adr

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // The falling-edge copy equals what the next rising edge samples.
    task automatic wait_rdy();
        logic r;
        int n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
            n++;
            if (n > 20) begin
                error_cnt++;
                give_verdict();
            end
        end while (r !== 1'b1);
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask : ahb

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask : rchk

    task automatic xfer(input int ch, input logic [15:0] load, input int nblk, input int gap,
                        input logic [15:0] left, input int ends, input int empt);
        int t = te_n[ch];
        int a = as_n[ch];
        int e = es_n[ch];
        ahb(1'b1, adr(ch, 1'b0), {16'h0, load});
        eng.run(ch, nblk, gap);
        rchk("count", adr(ch, 1'b0), {16'h0, left});
        check("ends", te_n[ch] - t, ends);
        check("auto stop", as_n[ch] - a, auto_stop_command_enable[ch] ? ends : 0);
        check("empty", es_n[ch] - e, empt);
    endtask : xfer

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        count_gate_bit = 2'h0;
        multi_block_select = 2'h0;
        auto_stop_command_enable = 2'h0;
        seed = 32'h0000B187;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            rchk("count reset", adr(k, 1'b0), 32'h0);
            rchk("argument reset", adr(k, 1'b1), 32'h0);
            for (int j = 0; j < 3; j++) begin
                v = rnd();
                ahb(1'b1, adr(k, 1'b1), v);
                rchk("argument", adr(k, 1'b1), v);
                check("frame", frame_argument[k], v);
                ahb(1'b1, adr(k, 1'b0), v);
                rchk("count", adr(k, 1'b0), {16'h0, v[15:0]});
            end
        end
        rchk("unmapped", 32'h00000100, 32'h0);
        count_gate_bit <= 2'h3;
        multi_block_select <= 2'h3;
        for (int j = 0; j < 6; j++) begin
            c = int'(rnd() % 2);
            auto_stop_command_enable <= 2'(rnd() % 4);
            v = 1 + rnd() % 8;
            xfer(c, v[15:0], int'(v), int'(rnd() % 3), 16'h0, 1, 0);
        end
        xfer(0, 16'h0, 0, 0, 16'h0, 0, 1);
        for (int m = 0; m < 2; m++) begin
            count_gate_bit[0] <= m[0];
            multi_block_select[0] <= ~m[0];
            xfer(0, 16'h4, 2, 1, 16'h4, 0, 0);
        end
        count_gate_bit <= 2'h3;
        multi_block_select <= 2'h3;
        ahb(1'b1, adr(1, 1'b0), 32'h7);
        xfer(0, 16'hFFFF, 1, 0, 16'hFFFE, 0, 0);
        xfer(0, 16'h3, 2, 0, 16'h1, 0, 0);
        xfer(0, 16'h1, 1, 0, 16'h0, 1, 0);
        rchk("other channel", adr(1, 1'b0), 32'h7);
        fork
            xfer(1, 16'h3, 3, 4, 16'h0, 1, 0);
            begin
                repeat (8) @(posedge hclk);
                ahb(1'b1, adr(1, 1'b0), 32'h9);
                check("response", {31'h0, hresp}, 32'h0);
            end
        join
        give_verdict();
    end
endmodule : sdbc_bank_tb_top
